/* design/fcs_defs.svh */
// Command codes, unlock addresses and bus timing counts for the flash command host.
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
`define FCS_ADDR_UNLOCK1   12'h555
`define FCS_ADDR_UNLOCK2   12'h2aa
`define FCS_ADDR_CFI       12'h055
`define FCS_ADDR_LOCKSTAT  12'h080
`define FCS_DATA_UNLOCK1   8'haa
`define FCS_DATA_UNLOCK2   8'h55
`define FCS_DATA_ERASE_PRE 8'h80
`define FCS_DATA_CHIP_ERA  8'h10
`define FCS_DATA_SECT_ERA  8'h30
`define FCS_DATA_LOCKDOWN  8'h60
`define FCS_DATA_PROGRAM   8'ha0
`define FCS_DATA_DUAL_PROG 8'he0
`define FCS_DATA_SUSPEND   8'hb0
`define FCS_DATA_RESUME    8'h30
`define FCS_DATA_ID_ENTRY  8'h90
`define FCS_DATA_ID_EXIT   8'hf0
`define FCS_DATA_PROT_PROG 8'hc0
`define FCS_DATA_PROT_LOCK 8'h00
`define FCS_DATA_CONFIG    8'hd0
`define FCS_DATA_CFI       8'h98
`define FCS_LOCK_BIT       1
`define FCS_CLK_MHZ        125
`define FCS_STROBE_NS      80
`define FCS_STROBE_CYC     ((`FCS_STROBE_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_BUSY_GUARD     3'd7
`endif

/* design/fcs_pkg.sv */
// Types shared by the flash command host.
package fcs_pkg;
  // Operations the user side can request.
  typedef enum logic [3:0] {
    FCS_OP_PROGRAM, FCS_OP_DUAL_PROG, FCS_OP_CHIP_ERASE, FCS_OP_SECT_ERASE,
    FCS_OP_LOCKDOWN, FCS_OP_SUSPEND, FCS_OP_RESUME, FCS_OP_ID_ENTRY,
    FCS_OP_ID_EXIT, FCS_OP_ID_EXIT_SHORT, FCS_OP_PROT_PROG, FCS_OP_PROT_LOCK,
    FCS_OP_LOCK_STATUS, FCS_OP_CONFIG, FCS_OP_CFI, FCS_OP_READ
  } fcs_op_t;
endpackage : fcs_pkg

/* design/fcs_bus_cycle.sv */
// One asynchronous write or read cycle on the flash parallel bus.
`timescale 1ns/10ps
`include "fcs_defs.svh"
module fcs_bus_cycle #(
  parameter int STROBE_CYC = `FCS_STROBE_CYC  // Strobe low time in clock cycles.
) (
  input  wire logic        sys_clk,    // System clock.
  input  wire logic        srst,       // Synchronous reset, active high.
  input  wire logic        start,      // Pulse: begin one cycle.
  input  wire logic        is_read,    // Level: cycle is a read.
  output logic             strobe_n,   // Write or output strobe, active low.
  output logic             sample,     // Pulse: read data may be taken now.
  output logic             done        // Pulse: cycle finished.
);
  logic [7:0] count;                   // Remaining strobe cycles.
  logic       active;                  // A cycle is in progress.
  logic       rd;                      // Current cycle is a read.
  wire        last = active && (count == 8'h00);  // Final strobe cycle.

  // Holds the strobe low for the set count, then releases it.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active   <= 1'b0;
      count    <= 8'h00;
      strobe_n <= 1'b1;
      sample   <= 1'b0;
      done     <= 1'b0;
      rd       <= 1'b0;
    end else begin
      sample <= last && rd;
      done   <= last;
      if (start && !active) begin
        active   <= 1'b1;
        rd       <= is_read;
        count    <= 8'(STROBE_CYC - 1);
        strobe_n <= 1'b0;
      end else if (last) begin
        active   <= 1'b0;
        strobe_n <= 1'b1;
      end else if (active) begin
        count <= count - 8'h01;
      end
    end
  end
endmodule : fcs_bus_cycle

/* design/fcs_host.sv */
// Host controller that issues command sequences to a parallel NOR flash.
// Functional notes
// - Multi-cycle commands begin with the unlock pair.
// - Use F0 for the identification exit.
// - Dual addresses differ only in bit zero.
// - Dual-word program for manufacturing use only.
// - Protection lock data bit one is low.
// - Identification exit follows protection register reads.
`timescale 1ns/10ps
`include "fcs_defs.svh"
module fcs_host
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 21,           // Word address width.
  parameter int DATA_W = 16            // Data bus width.
) (
  input  wire logic              sys_clk,       // System clock, 125 MHz.
  input  wire logic              srst,          // Synchronous reset, active high.
  input  wire logic              req_valid,     // Level: request offered.
  output logic                   req_ready,     // Level: idle, request taken.
  input  wire fcs_pkg::fcs_op_t  req_op,        // Requested operation.
  input  wire logic [ADDR_W-1:0] first_word_address,   // Target or sector address.
  input  wire logic [DATA_W-1:0] first_word_data,      // Data for the first word.
  input  wire logic [DATA_W-1:0] second_word_data,     // Data for the second word.
  input  wire logic              high_volt_ok,  // Level: protection supply at 12V.
  output logic                   resp_valid,    // Pulse: request finished.
  output logic                   resp_error,    // Level with resp_valid: refused.
  output logic [DATA_W-1:0]      resp_data,     // Read data or lock state.
  output logic                   lock_state_bit, // Last block lock bit read.
  output logic                   flash_busy,    // Level: device busy pin seen low.
  output logic [ADDR_W-1:0]      fl_addr,       // Flash address pins.
  output logic [DATA_W-1:0]      fl_dq_out,     // Flash data out.
  output logic                   fl_dq_oe,      // Flash data drive enable.
  input  wire logic [DATA_W-1:0] fl_dq_in,      // Flash data in.
  output logic                   fl_ce_n,       // Chip enable, active low.
  output logic                   fl_we_n,       // Write enable, active low.
  output logic                   fl_oe_n,       // Output enable, active low.
  input  wire logic              fl_ready_in    // Open-drain ready pin, low is busy.
);
  // Sequencer states.
  typedef enum logic [1:0] {FCS_IDLE, FCS_SEND, FCS_WAIT} fcs_state_t;

  fcs_state_t        state;            // Sequencer state.
  fcs_op_t           op;               // Latched operation.
  logic [ADDR_W-1:0] addr;             // Latched user address.
  logic [DATA_W-1:0] d1;               // Latched first data.
  logic [DATA_W-1:0] d2;               // Latched second data.
  logic [2:0]        step;             // Index of the bus cycle being sent.
  logic [DATA_W-1:0] dq_s1;            // Data synchroniser first stage.
  logic [DATA_W-1:0] dq_s2;            // Data synchroniser second stage.
  logic              rdy_s1;           // Ready synchroniser first stage.
  logic              rdy_s2;           // Ready synchroniser second stage.
  logic              id_open;          // Identification mode left open by a protection read.
  logic              cyc_start;        // Pulse to the bus cycle engine.
  logic              cyc_done;         // Bus cycle finished.
  logic              cyc_sample;       // Read data may be taken.
  logic              strobe_n;         // Strobe from the engine.

  // Builds a command address in the low twelve bits, upper bits zero.
  function automatic logic [ADDR_W-1:0] cmd_addr(input logic [11:0] a);
    cmd_addr = {{(ADDR_W-12){1'b0}}, a};
  endfunction : cmd_addr

  // Places a command byte in the low lane with the upper lane zero.
  function automatic logic [DATA_W-1:0] cmd_data(input logic [7:0] d);
    cmd_data = {{(DATA_W-8){1'b0}}, d};
  endfunction : cmd_data

  // Total bus cycles of each operation.
  wire [2:0] op_len =
    (op == FCS_OP_CHIP_ERASE || op == FCS_OP_SECT_ERASE || op == FCS_OP_LOCKDOWN) ? 3'd6 :
    (op == FCS_OP_DUAL_PROG) ? 3'd5 :
    (op == FCS_OP_PROGRAM || op == FCS_OP_PROT_PROG || op == FCS_OP_PROT_LOCK ||
     op == FCS_OP_LOCK_STATUS || op == FCS_OP_CONFIG) ? 3'd4 :
    (op == FCS_OP_ID_ENTRY || op == FCS_OP_ID_EXIT) ? 3'd3 : 3'd1;
  wire single = (op_len == 3'd1);      // One-cycle command without unlock.
  // Third-cycle command byte.
  wire [7:0] third_byte =
    (op == FCS_OP_PROGRAM)    ? `FCS_DATA_PROGRAM :
    (op == FCS_OP_DUAL_PROG)  ? `FCS_DATA_DUAL_PROG :
    (op == FCS_OP_ID_ENTRY || op == FCS_OP_LOCK_STATUS) ? `FCS_DATA_ID_ENTRY :
    (op == FCS_OP_ID_EXIT)    ? `FCS_DATA_ID_EXIT :
    (op == FCS_OP_PROT_PROG || op == FCS_OP_PROT_LOCK) ? `FCS_DATA_PROT_PROG :
    (op == FCS_OP_CONFIG)     ? `FCS_DATA_CONFIG : `FCS_DATA_ERASE_PRE;
  // Sixth-cycle byte of erase and lockdown sequences.
  wire [7:0] sixth_byte =
    (op == FCS_OP_CHIP_ERASE) ? `FCS_DATA_CHIP_ERA :
    (op == FCS_OP_LOCKDOWN)   ? `FCS_DATA_LOCKDOWN : `FCS_DATA_SECT_ERA;
  // Single-cycle command address and data.
  wire [ADDR_W-1:0] single_addr =
    (op == FCS_OP_CFI) ? cmd_addr(`FCS_ADDR_CFI) : (op == FCS_OP_READ) ? addr : '0;
  wire [DATA_W-1:0] single_data =
    (op == FCS_OP_SUSPEND) ? cmd_data(`FCS_DATA_SUSPEND) :
    (op == FCS_OP_RESUME)  ? cmd_data(`FCS_DATA_RESUME) :
    (op == FCS_OP_CFI)     ? cmd_data(`FCS_DATA_CFI) : cmd_data(`FCS_DATA_ID_EXIT);
  // Cycle four and beyond, per operation.
  wire [ADDR_W-1:0] late_addr =
    (op == FCS_OP_DUAL_PROG && step == 3'd4) ? {addr[ADDR_W-1:1], 1'b1} :
    (op == FCS_OP_DUAL_PROG) ? {addr[ADDR_W-1:1], 1'b0} :
    (op == FCS_OP_PROT_LOCK || op == FCS_OP_LOCK_STATUS) ? cmd_addr(`FCS_ADDR_LOCKSTAT) :
    (op == FCS_OP_CONFIG) ? '0 :
    (step == 3'd5 && op == FCS_OP_CHIP_ERASE) ? cmd_addr(`FCS_ADDR_UNLOCK1) :
    (step == 3'd5) ? addr :
    (step == 3'd3 && (op == FCS_OP_CHIP_ERASE || op == FCS_OP_SECT_ERASE || op == FCS_OP_LOCKDOWN)) ?
      cmd_addr(`FCS_ADDR_UNLOCK1) :
    (step == 3'd4) ? cmd_addr(`FCS_ADDR_UNLOCK2) : addr;
  wire [DATA_W-1:0] late_data =
    (op == FCS_OP_DUAL_PROG && step == 3'd4) ? d2 :
    (op == FCS_OP_PROT_LOCK) ? cmd_data(`FCS_DATA_PROT_LOCK) :
    (op == FCS_OP_CONFIG) ? cmd_data({7'h00, d1[0]}) :
    (step == 3'd5) ? cmd_data(sixth_byte) :
    (step == 3'd3 && (op == FCS_OP_CHIP_ERASE || op == FCS_OP_SECT_ERASE || op == FCS_OP_LOCKDOWN)) ?
      cmd_data(`FCS_DATA_UNLOCK1) :
    (step == 3'd4) ? cmd_data(`FCS_DATA_UNLOCK2) : d1;
  // Address and data for the current step.
  wire [ADDR_W-1:0] step_addr =
    single ? single_addr :
    (step == 3'd0 || step == 3'd2) ? cmd_addr(`FCS_ADDR_UNLOCK1) :
    (step == 3'd1) ? cmd_addr(`FCS_ADDR_UNLOCK2) : late_addr;
  wire [DATA_W-1:0] step_data =
    single ? single_data :
    (step == 3'd0) ? cmd_data(`FCS_DATA_UNLOCK1) :
    (step == 3'd1) ? cmd_data(`FCS_DATA_UNLOCK2) :
    (step == 3'd2) ? cmd_data(third_byte) : late_data;
  // Final cycle of status and array reads is a read.
  wire step_read = (op == FCS_OP_READ) || (op == FCS_OP_LOCK_STATUS && step == 3'd3);
  wire last_step = (step == op_len - 3'd1);
  // Whether the operation starts an internal program or erase cycle.
  wire waits_ready = (op == FCS_OP_PROGRAM || op == FCS_OP_DUAL_PROG || op == FCS_OP_CHIP_ERASE ||
                      op == FCS_OP_SECT_ERASE || op == FCS_OP_PROT_PROG || op == FCS_OP_RESUME);
  // Operations still allowed while a protection read has left identification mode open.
  wire id_ok = (req_op == FCS_OP_ID_EXIT || req_op == FCS_OP_ID_EXIT_SHORT ||
                req_op == FCS_OP_LOCK_STATUS || req_op == FCS_OP_READ);
  // Dual program only with the twelve-volt supply, as in a production setup.
  wire refuse = ((req_op == FCS_OP_DUAL_PROG) && !high_volt_ok) ||
                (id_open && !id_ok);

  fcs_bus_cycle u_cycle (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .start    (cyc_start),
    .is_read  (step_read),
    .strobe_n (strobe_n),
    .sample   (cyc_sample),
    .done     (cyc_done)
  );

  // Brings the pin inputs into the clock domain.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dq_s1  <= '0;
      dq_s2  <= '0;
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
    end else begin
      dq_s1  <= fl_dq_in;
      dq_s2  <= dq_s1;
      rdy_s1 <= fl_ready_in;
      rdy_s2 <= rdy_s1;
    end
  end

  // Steps through the bus cycles of the latched command.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= FCS_IDLE;
      op <= FCS_OP_READ;
      addr <= '0;
      d1 <= '0;
      d2 <= '0;
      step <= 3'd0;
      cyc_start <= 1'b0;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_data <= '0;
      lock_state_bit <= 1'b1;
      id_open <= 1'b0;
      flash_busy <= 1'b0;
      fl_addr <= '0;
      fl_dq_out <= '0;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
    end else begin
      cyc_start <= 1'b0;
      resp_valid <= 1'b0;
      flash_busy <= !rdy_s2;
      fl_ce_n <= strobe_n && !cyc_start;
      fl_we_n <= strobe_n || step_read || state != FCS_SEND;
      fl_oe_n <= strobe_n || !step_read || state != FCS_SEND;
      unique case (state)
        FCS_IDLE: begin
          req_ready <= !req_ready && !req_valid;
          fl_dq_oe <= 1'b0;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            if (refuse) begin
              resp_valid <= 1'b1;
              resp_error <= 1'b1;
            end else begin
              op <= req_op;
              addr <= first_word_address;
              d1 <= first_word_data;
              d2 <= second_word_data;
              step <= 3'd0;
              resp_error <= 1'b0;
              // A status read opens identification mode; only an exit closes it.
              if (req_op == FCS_OP_LOCK_STATUS) begin
                id_open <= 1'b1;
              end else if (req_op == FCS_OP_ID_EXIT || req_op == FCS_OP_ID_EXIT_SHORT) begin
                id_open <= 1'b0;
              end
              state <= FCS_SEND;
              cyc_start <= 1'b1;
            end
          end else begin
            req_ready <= 1'b1;
          end
        end
        FCS_SEND: begin
          fl_addr <= step_addr;
          fl_dq_out <= step_data;
          fl_dq_oe <= !step_read;
          if (cyc_sample) begin
            resp_data <= dq_s2;
            if (op == FCS_OP_LOCK_STATUS) begin
              lock_state_bit <= dq_s2[`FCS_LOCK_BIT];
            end
          end
          if (cyc_done) begin
            if (last_step) begin
              state <= waits_ready ? FCS_WAIT : FCS_IDLE;
              step <= 3'd0;  // Reused as the busy guard counter.
              if (!waits_ready) begin
                resp_valid <= 1'b1;
              end
            end else begin
              step <= step + 3'd1;
              cyc_start <= 1'b1;
            end
          end
        end
        FCS_WAIT: begin
          fl_dq_oe <= 1'b0;
          // The busy pin reaches flash_busy several edges late, so a short guard comes first.
          if (step != `FCS_BUSY_GUARD) begin
            step <= step + 3'd1;
          end else if (rdy_s2 && !flash_busy) begin
            resp_valid <= 1'b1;
            state <= FCS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : fcs_host

/* testbench/fcs_flash_model.sv */
// Behavioural flash device that answers the host's bus cycles.
`timescale 1ns/10ps
module fcs_flash_model #(
  parameter int BUSY_NS = 400           // Internal program or erase time, shortened.
) (
  input  wire logic [20:0] fl_addr,     // Address pins.
  input  wire logic [15:0] fl_dq_out,   // Data driven by the host.
  input  wire logic        fl_ce_n,     // Chip enable, active low.
  input  wire logic        fl_we_n,     // Write enable, active low.
  input  wire logic        fl_oe_n,     // Output enable, active low.
  output logic      [15:0] fl_dq_in,    // Data driven to the host.
  output logic             fl_ready_in  // Ready pin, low while busy.
);
  logic [20:0] wa[$];                   // Logged write addresses.
  logic [15:0] wd[$];                   // Logged write data.
  logic [7:0]  prev       = 8'h00;      // Command byte of the last write.
  logic [7:0]  prev2      = 8'h00;      // Command byte two writes back.
  logic [7:0]  cfg        = 8'h00;      // Configuration register, clear at power-up.
  logic        id_mode    = 1'b0;       // Identification or query mode.
  logic        blk_locked = 1'b0;       // User protection block locked.
  logic        armed      = 1'b0;       // Write strobe and select both low.
  initial begin
    fl_ready_in = 1'b1;
    fl_dq_in    = 16'h0000;
  end
  // Log each write when the strobe or the select ends it; decode the low byte and low address bits only.
  always @(fl_we_n, fl_ce_n) begin
    if (!fl_we_n && !fl_ce_n) begin
      armed = 1'b1;
    end else if (armed) begin
      armed = 1'b0;
      wa.push_back(fl_addr);
      wd.push_back(fl_dq_out);
      if (prev == 8'h55 && fl_addr[11:0] == 12'h555 && fl_dq_out[7:0] == 8'h90) id_mode = 1'b1;
      if (fl_addr[11:0] == 12'h055 && fl_dq_out[7:0] == 8'h98) id_mode = 1'b1;
      if (fl_dq_out[7:0] == 8'hf0) id_mode = 1'b0;
      if (prev == 8'hd0) cfg = fl_dq_out[7:0];
      if (prev == 8'hc0 && fl_addr[7:0] == 8'h80 && !fl_dq_out[1]) blk_locked = 1'b1;
      // Program, erase and resume hold the ready pin low for the internal cycle.
      if (prev == 8'ha0 || prev2 == 8'he0 || fl_dq_out[7:0] == 8'h10 || fl_dq_out[7:0] == 8'h30) begin
        fork
          begin
            fl_ready_in = 1'b0;
            #(BUSY_NS) fl_ready_in = 1'b1;
          end
        join_none
      end
      prev2 = prev;
      prev  = fl_dq_out[7:0];
    end
  end
  // Drive read data while selected; a released bus shows a changing pattern.
  always @(fl_ce_n, fl_oe_n, fl_addr) begin
    if (!fl_ce_n && !fl_oe_n) begin
      fl_dq_in = (id_mode && fl_addr[11:0] == 12'h080) ? {14'h0000, !blk_locked, 1'b0} : fl_addr[15:0] ^ 16'h5a5a;
    end else begin
      fl_dq_in = ~fl_dq_in;
    end
  end
endmodule : fcs_flash_model

/* testbench/fcs_host_chk.sv */
// Port-level checks on the flash command host.
`timescale 1ns/10ps
module fcs_host_chk
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 21,                    // Word address width.
  parameter int DATA_W = 16                     // Data bus width.
) (
  input wire logic              sys_clk,        // System clock.
  input wire logic              srst,           // Synchronous reset.
  input wire logic              req_valid,      // Request offered.
  input wire logic              req_ready,      // Host idle.
  input wire fcs_pkg::fcs_op_t  req_op,         // Requested operation.
  input wire logic              high_volt_ok,   // Protection supply present.
  input wire logic              resp_valid,     // Request finished.
  input wire logic              resp_error,     // Request refused.
  input wire logic              flash_busy,     // Busy seen.
  input wire logic [ADDR_W-1:0] fl_addr,        // Address pins.
  input wire logic [DATA_W-1:0] fl_dq_out,      // Data out.
  input wire logic              fl_dq_oe,       // Data drive enable.
  input wire logic              fl_ce_n,        // Chip enable.
  input wire logic              fl_we_n,        // Write enable.
  input wire logic              fl_oe_n,        // Output enable.
  input wire logic              fl_ready_in     // Ready pin.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  strobe_excl_a: assert property (fl_we_n || fl_oe_n) else $error("Both strobes low.");
  write_drive_a: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe) else $error("Write without select or drive.");
  read_float_a: assert property (!fl_oe_n |-> !fl_ce_n && !fl_dq_oe) else $error("Read while driving.");
  idle_quiet_a: assert property (req_ready |-> fl_we_n && fl_oe_n) else $error("Strobe active while idle.");
  resp_pulse_a: assert property (resp_valid |=> !resp_valid) else $error("Response longer than one cycle.");
  dual_refuse_a: assert property (req_valid && req_ready && req_op == FCS_OP_DUAL_PROG && !high_volt_ok
    |-> fl_we_n throughout (##[1:2] (resp_valid && resp_error))) else $error("Dual program not refused.");
  busy_clear_a: assert property (fl_ready_in [*5] |-> !flash_busy) else $error("Busy while ready.");
  busy_seen_a: assert property (!fl_ready_in [*5] |-> flash_busy) else $error("Busy pin missed.");
  strobe_len_a: assert property ($fell(fl_we_n) |-> !fl_we_n [*8]) else $error("Write strobe too short.");
  write_hold_a: assert property (!fl_we_n && $past(!fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("Write cycle changed mid-strobe.");
endmodule : fcs_host_chk
bind fcs_host fcs_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.sys_clk, .srst, .req_valid, .req_ready,
  .req_op, .high_volt_ok, .resp_valid, .resp_error, .flash_busy, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_ce_n,
  .fl_we_n, .fl_oe_n, .fl_ready_in);

/* testbench/tb_fcs_host.sv */
// Self-checking bench for the flash command host.
`timescale 1ns/10ps
`define CMP(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_fcs_host;
  import fcs_pkg::*;
  logic        sys_clk, srst, req_valid, req_ready, high_volt_ok, resp_valid, resp_error, lock_state_bit;
  logic        flash_busy, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_ready_in, seen_busy;
  fcs_op_t     req_op;
  logic [20:0] first_word_address, fl_addr;
  logic [15:0] first_word_data, second_word_data, resp_data, fl_dq_out, fl_dq_in;
  int          failures, comparisons;
  fcs_host dut (.sys_clk, .srst, .req_valid, .req_ready, .req_op, .first_word_address, .first_word_data,
    .second_word_data, .high_volt_ok, .resp_valid, .resp_error, .resp_data, .lock_state_bit, .flash_busy,
    .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_dq_in, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_ready_in);
  fcs_flash_model flash (.fl_addr, .fl_dq_out, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_dq_in, .fl_ready_in);
  // Clock at 125 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Remember that the host reported the device busy.
  always @(posedge sys_clk) if (flash_busy === 1'b1) seen_busy <= 1'b1;
  // Print the verdict and stop.
  task close_out;
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // Issue one request, wait for it to be taken and for its response.
  task automatic run(input fcs_op_t op, input logic [20:0] a, input logic [15:0] d1, input logic [15:0] d2);
    int n;
    flash.wa.delete();
    flash.wd.delete();
    req_op = op; first_word_address = a; first_word_data = d1; second_word_data = d2; req_valid = 1'b1;
    while (req_ready !== 1'b1) begin @(posedge sys_clk); #1; end
    @(posedge sys_clk); #1;
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 20000) begin @(posedge sys_clk); #1; n++; end
    `CMP("resp", 1'b1, resp_valid)
  endtask : run
  // Check the write count, the unlock pair and the last write.
  task automatic seq(input int n, input logic [20:0] la, input logic [15:0] ld, input bit ca);
    `CMP("count", n, flash.wd.size())
    if (n >= 3) begin
      `CMP("ua1", 21'h000555, flash.wa[0])
      `CMP("ud1", 16'h00aa, flash.wd[0])
      `CMP("ua2", 21'h0002aa, flash.wa[1])
      `CMP("ud2", 16'h0055, flash.wd[1])
    end
    if (n > 0 && ca) `CMP("la", la, flash.wa[n-1])
    if (n > 0) `CMP("ld", ld, flash.wd[n-1])
  endtask : seq
  // Word program with junk in the upper address bits.
  task automatic t_program;
    seen_busy = 1'b0;
    run(FCS_OP_PROGRAM, 21'h1abcde, 16'hbeef, 16'h0000);
    seq(4, 21'h1abcde, 16'hbeef, 1);
    `CMP("pcmd", 16'h00a0, flash.wd[2])
    `CMP("busy", 1'b1, seen_busy)
  endtask : t_program
  // Chip erase, sector erase and lockdown.
  task automatic t_erase;
    fcs_op_t     ops[3] = '{FCS_OP_CHIP_ERASE, FCS_OP_SECT_ERASE, FCS_OP_LOCKDOWN};
    logic [15:0] cmd[3] = '{16'h0010, 16'h0030, 16'h0060};
    for (int i = 0; i < 3; i++) begin
      run(ops[i], 21'h123456, 16'h0000, 16'h0000);
      seq(6, (i == 0) ? 21'h000555 : 21'h123456, cmd[i], 1);
      `CMP("pre", 16'h0080, flash.wd[2])
    end
  endtask : t_erase
  // Dual-word program with and without the protection supply.
  task automatic t_dual;
    high_volt_ok = 1'b1;
    run(FCS_OP_DUAL_PROG, 21'h0f0f0, 16'h1111, 16'h2222);
    seq(5, 21'h0f0f1, 16'h2222, 1);
    `CMP("a1", 21'h0f0f0, flash.wa[3])
    `CMP("d1", 16'h1111, flash.wd[3])
    high_volt_ok = 1'b0;
    run(FCS_OP_DUAL_PROG, 21'h0f0f0, 16'h1111, 16'h2222);
    `CMP("err", 1'b1, resp_error)
    seq(0, 21'h0, 16'h0, 0);
  endtask : t_dual
  // Single-cycle commands, identification entry and exits, configuration.
  task automatic t_single;
    fcs_op_t     ops[7] = '{FCS_OP_SUSPEND, FCS_OP_RESUME, FCS_OP_ID_ENTRY, FCS_OP_CFI, FCS_OP_ID_EXIT_SHORT,
                            FCS_OP_ID_ENTRY, FCS_OP_ID_EXIT};
    int          n[7]   = '{1, 1, 3, 1, 1, 3, 3};
    logic [15:0] d[7]   = '{16'h00b0, 16'h0030, 16'h0090, 16'h0098, 16'h00f0, 16'h0090, 16'h00f0};
    for (int i = 0; i < 7; i++) begin
      run(ops[i], 21'h1fffff, 16'h0001, 16'h0000);
      seq(n[i], (ops[i] == FCS_OP_CFI) ? 21'h000055 : 21'h000555, d[i], n[i] == 3 || ops[i] == FCS_OP_CFI);
    end
    `CMP("idoff", 1'b0, flash.id_mode)
    `CMP("cfg0", 8'h00, flash.cfg)
    run(FCS_OP_CONFIG, 21'h000000, 16'h0001, 16'h0000);
    seq(4, 21'h0, 16'h0001, 0);
    `CMP("ccmd", 16'h00d0, flash.wd[2])
    `CMP("cfg1", 8'h01, flash.cfg)
  endtask : t_single
  // Protection block status before and after locking it.
  task automatic t_lock;
    run(FCS_OP_LOCK_STATUS, 21'h0, 16'h0000, 16'h0000);
    `CMP("open", 1'b1, lock_state_bit)
    `CMP("rd0", 1'b1, resp_data[1])
    run(FCS_OP_PROGRAM, 21'h0, 16'h0000, 16'h0000);
    `CMP("idlock", 1'b1, resp_error)
    seq(0, 21'h0, 16'h0, 0);
    run(FCS_OP_ID_EXIT_SHORT, 21'h0, 16'h0000, 16'h0000);
    run(FCS_OP_PROT_LOCK, 21'h0, 16'h0000, 16'h0000);
    `CMP("lcmd", 16'h00c0, flash.wd[2])
    `CMP("lbit", 1'b0, flash.wd[3][1])
    run(FCS_OP_LOCK_STATUS, 21'h0, 16'h0000, 16'h0000);
    `CMP("shut", 1'b0, lock_state_bit)
    `CMP("rd1", 1'b0, resp_data[1])
    run(FCS_OP_ID_EXIT_SHORT, 21'h0, 16'h0000, 16'h0000);
    run(FCS_OP_READ, 21'h012345, 16'h0000, 16'h0000);
    `CMP("rdata", 16'h2345 ^ 16'h5a5a, resp_data)
  endtask : t_lock
  // Reset, then the scenarios in turn.
  initial begin
    srst = 1'b1; req_valid = 1'b0; req_op = FCS_OP_READ; first_word_address = 21'h0;
    first_word_data = 16'h0000; second_word_data = 16'h0000; high_volt_ok = 1'b0;
    failures = 0; comparisons = 0; seen_busy = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 srst = 1'b0;
    t_program;
    t_erase;
    t_dual;
    t_single;
    t_lock;
    close_out;
  end
  // Cut a hang short well after the scenarios should have ended.
  initial begin
    #400000;
    failures++;
    close_out;
  end
endmodule : tb_fcs_host
